// ---- hw/alc_alert_limit.v ----
`timescale 1ns/100ps
`include "alc_defines.vh"
module alc_alert_limit (
  // clock and reset
  input wire i_clk_sys,
  input wire i_nrst,
  // register port from the serial bus unit
  input wire [7:0] i_reg_addr,
  input wire i_reg_wr,
  input wire [15:0] i_reg_wdata,
  input wire i_reg_rd,
  output reg [15:0] o_reg_rdata,
  output reg o_reg_rvalid,
  // converter unit
  input wire i_conv_done,
  input wire i_conv_kind,
  input wire [15:0] i_sense_code,
  input wire [15:0] i_bus_code,
  input wire i_cycle_done,
  input wire i_cfg_wr,
  input wire i_cfg_pd,
  // power multiplier result, valid one cycle after the current result
  input wire i_power_valid,
  input wire [15:0] i_power,
  input wire i_power_ovf,
  // results out
  output reg [15:0] o_current,
  output reg o_current_valid,
  output reg [15:0] o_cal,
  // alert pin, open drain
  input wire i_alert_pin,
  output reg o_alert_out,
  output reg o_alert_oe
);
  reg [15:0] cal_q;
  reg [15:0] cal_d;
  reg [15:0] mask_q;
  reg [15:0] mask_d;
  reg [15:0] limit_q;
  reg [15:0] limit_d;
  reg hit_q;
  reg hit_d;
  reg done_q;
  reg done_d;
  reg ovf_q;
  reg ovf_d;
  reg bus_cmp_q;
  reg [15:0] bus_hold_q;
  wire mask_rd;
  wire [4:0] sel;
  wire mul_valid;
  wire [15:0] mul_current;
  wire mul_ovf;
  wire eval_sense;
  wire eval_bus;
  wire eval_power;
  wire eval_any;
  reg fault;
  wire limit_alert;
  wire alert_active;
  localparam ST_IDLE = 2'b01;
  localparam ST_WAIT = 2'b10;
  reg [1:0] st_q;
  reg [1:0] st_d;

  // unsigned greater / less
  function [1:0] ucmp;
    input [15:0] a;
    input [15:0] b;
    begin
      ucmp = {(a > b), (a < b)};
    end
  endfunction

  // signed greater / less
  function [1:0] scmp;
    input [15:0] a;
    input [15:0] b;
    begin
      scmp = {($signed(a) > $signed(b)), ($signed(a) < $signed(b))};
    end
  endfunction

  // priority pick of the limit function
  function [4:0] pick_top;
    input [4:0] en;
    begin
      casez (en)
        5'b1????: pick_top = 5'b10000;
        5'b01???: pick_top = 5'b01000;
        5'b001??: pick_top = 5'b00100;
        5'b0001?: pick_top = 5'b00010;
        5'b00001: pick_top = 5'b00001;
        default: pick_top = 5'b00000;
      endcase
    end
  endfunction

  assign mask_rd = i_reg_rd && (i_reg_addr == `ALC_REG_MASK);
  assign sel = pick_top(mask_q[`ALC_SENSE_OVER_ENABLE_BIT:`ALC_POVL_BIT]);

  alc_scale_mult u_mult (
    .i_clk_sys(i_clk_sys),
    .i_nrst(i_nrst),
    .i_start(i_conv_done && (i_conv_kind == `ALC_KIND_SENSE)),
    .i_sense(i_sense_code),
    .i_cal(cal_q),
    .o_valid(mul_valid),
    .o_current(mul_current),
    .o_ovf(mul_ovf)
  );

  assign eval_sense = i_conv_done && (i_conv_kind == `ALC_KIND_SENSE);
  assign eval_bus = i_conv_done && (i_conv_kind == `ALC_KIND_BUS);
  assign eval_power = i_power_valid && bus_cmp_q;
  assign eval_any = eval_sense || eval_bus || eval_power;

  always @* begin
    fault = 1'b0;
    if (sel[4] && eval_sense) begin
      fault = scmp(i_sense_code, limit_q) == 2'b10;
    end
    if (sel[3] && eval_sense) begin
      fault = scmp(i_sense_code, limit_q) == 2'b01;
    end
    if (sel[2] && eval_bus) begin
      fault = ucmp(i_bus_code, limit_q) == 2'b10;
    end
    if (sel[1] && eval_bus) begin
      fault = ucmp(i_bus_code, limit_q) == 2'b01;
    end
    if (sel[0] && eval_power) begin
      fault = ucmp(i_power, limit_q) == 2'b10;
    end
  end

  // function evaluations that concern the selected source
  wire sel_eval;
  assign sel_eval = ((sel[4] || sel[3]) && eval_sense) ||
                    ((sel[2] || sel[1]) && eval_bus) || (sel[0] && eval_power);

  // power compare armed by a bus conversion
  always @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      bus_cmp_q <= 1'b0;
      bus_hold_q <= 16'h0000;
    end else begin
      if (eval_bus) begin
        bus_cmp_q <= 1'b1;
        bus_hold_q <= i_bus_code;
      end else if (i_power_valid) begin
        bus_cmp_q <= 1'b0;
      end
    end
  end

  // register writes
  always @* begin
    cal_d = cal_q;
    mask_d = mask_q;
    limit_d = limit_q;
    if (i_reg_wr) begin
      case (i_reg_addr)
        `ALC_REG_CAL: cal_d = i_reg_wdata & `ALC_CAL_WR_BITS;
        // reserved and flag bits not written
        `ALC_REG_MASK: mask_d = i_reg_wdata & `ALC_MASK_WR_BITS;
        `ALC_REG_LIMIT: limit_d = i_reg_wdata;
        default: cal_d = cal_q;
      endcase
    end
  end

  // done flag wait state: cycle end may follow a sense multiply
  always @* begin
    st_d = st_q;
    case (st_q)
      ST_IDLE: if (i_cycle_done) st_d = ST_WAIT;
      ST_WAIT: st_d = ST_IDLE;
      default: st_d = ST_IDLE;
    endcase
  end

  // flags, set wins over clear
  always @* begin
    done_d = done_q;
    hit_d = hit_q;
    ovf_d = ovf_q;
    // done clears on mask read or on a config write with i_cfg_pd low
    if ((i_cfg_wr && !i_cfg_pd) || mask_rd) begin
      done_d = 1'b0;
    end
    if (st_q == ST_WAIT) begin
      done_d = 1'b1;
    end
    if (mask_q[`ALC_LATCH_BIT]) begin
      if (mask_rd) begin
        hit_d = 1'b0;
      end
    end else begin
      if (sel_eval && !fault) begin
        hit_d = 1'b0;
      end
    end
    if (sel_eval && fault) begin
      hit_d = 1'b1;
    end
    if (mul_valid || i_power_valid) begin
      ovf_d = (mul_valid && mul_ovf) || (i_power_valid && i_power_ovf);
    end
  end

  assign limit_alert = hit_d;
  assign alert_active = limit_alert || (mask_q[`ALC_RDY_EN_BIT] && done_d);

  always @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      cal_q <= `ALC_CAL_RST;
      mask_q <= `ALC_MASK_RST;
      limit_q <= `ALC_LIMIT_RST;
      hit_q <= 1'b0;
      done_q <= 1'b0;
      ovf_q <= 1'b0;
      st_q <= ST_IDLE;
      o_reg_rdata <= 16'h0000;
      o_reg_rvalid <= 1'b0;
      o_current <= 16'h0000;
      o_current_valid <= 1'b0;
      o_cal <= 16'h0000;
      o_alert_out <= 1'b0;
      o_alert_oe <= 1'b0;
    end else begin
      cal_q <= cal_d;
      mask_q <= mask_d;
      limit_q <= limit_d;
      hit_q <= hit_d;
      done_q <= done_d;
      ovf_q <= ovf_d;
      st_q <= st_d;
      o_cal <= cal_d;
      o_current <= mul_valid ? mul_current : o_current;
      o_current_valid <= mul_valid;
      o_reg_rvalid <= i_reg_rd;
      if (i_reg_rd) begin
        case (i_reg_addr)
          `ALC_REG_CAL: o_reg_rdata <= cal_q;
          `ALC_REG_MASK: o_reg_rdata <= {mask_q[15:10], 5'h00, hit_q, done_q, ovf_q,
                                         mask_q[1:0]};
          `ALC_REG_LIMIT: o_reg_rdata <= limit_q;
          default: o_reg_rdata <= 16'h0000;
        endcase
      end
      // polarity: pull low when active-low, release when active-high
      o_alert_out <= 1'b0;
      o_alert_oe <= mask_q[`ALC_POL_BIT] ? ~alert_active : alert_active;
    end
  end
endmodule // alc_alert_limit

// ---- hw/alc_defines.vh ----
`ifndef ALC_DEFINES_VH
`define ALC_DEFINES_VH
// register offsets
`define ALC_REG_CAL 8'h05
`define ALC_REG_MASK 8'h06
`define ALC_REG_LIMIT 8'h07
// mask and enable field positions
`define ALC_SENSE_OVER_ENABLE_BIT 15
`define ALC_SENSE_UNDER_ENABLE_BIT 14
`define ALC_BUS_OVER_ENABLE_BIT 13
`define ALC_BUS_UNDER_ENABLE_BIT 12
`define ALC_POVL_BIT 11
`define ALC_RDY_EN_BIT 10
`define ALC_HIT_BIT 4
`define ALC_DONE_BIT 3
`define ALC_OVF_BIT 2
`define ALC_POL_BIT 1
`define ALC_LATCH_BIT 0
// writable bits of the mask and enable register and of the calibration register
`define ALC_MASK_WR_BITS 16'hFC03
`define ALC_CAL_WR_BITS 16'h7FFF
// reset values
`define ALC_CAL_RST 16'h0000
`define ALC_MASK_RST 16'h0000
`define ALC_LIMIT_RST 16'h0000
// result kinds on the conversion strobe
`define ALC_KIND_SENSE 1'b0
`define ALC_KIND_BUS 1'b1
`endif

// ---- hw/alc_scale_mult.v ----
`timescale 1ns/100ps
// registered multiply of signed sense code by calibration, with saturation
module alc_scale_mult (
  // clock and reset
  input wire i_clk_sys,
  input wire i_nrst,
  // operands
  input wire i_start,
  input wire [15:0] i_sense,
  input wire [15:0] i_cal,
  // result
  output reg o_valid,
  output reg [15:0] o_current,
  output reg o_ovf
);
  wire signed [32:0] prod;
  wire hi_ok;
  assign prod = $signed(i_sense) * $signed({1'b0, i_cal});
  // product fits in 16 signed bits when bits 32..15 all equal
  assign hi_ok = (prod[32:15] == {18{1'b0}}) || (prod[32:15] == {18{1'b1}});
  always @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      o_valid <= 1'b0;
      o_current <= 16'h0000;
      o_ovf <= 1'b0;
    end else begin
      o_valid <= i_start;
      if (i_start) begin
        o_ovf <= ~hi_ok;
        if (hi_ok) begin
          o_current <= prod[15:0];
        end else if (prod[32]) begin
          o_current <= 16'h8000;
        end else begin
          o_current <= 16'h7FFF;
        end
      end
    end
  end
endmodule // alc_scale_mult

// ---- sim/alc_alert_limit_asserts.sv ----
`timescale 1ns/100ps
module alc_alert_limit_asserts (
  // watched ports
  input wire i_clk_sys, i_nrst, i_reg_wr, i_reg_rd, i_conv_done, i_conv_kind,
  input wire [7:0] i_reg_addr,
  input wire [15:0] i_reg_wdata, o_reg_rdata, i_sense_code, i_bus_code,
  input wire o_current_valid, o_alert_out, o_alert_oe,
  input wire [15:0] o_cal
);
  reg [15:0] lim_q;
  reg [15:0] msk_q;
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_nrst);
  // shadow copies of limit and mask
  always @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      lim_q <= 16'h0000;
      msk_q <= 16'h0000;
    end else begin
      if (i_reg_wr && i_reg_addr == 8'h07) lim_q <= i_reg_wdata;
      if (i_reg_wr && i_reg_addr == 8'h06) msk_q <= i_reg_wdata & 16'hFC03;
    end
  end
  chk_cal_msb_zero: assert property (o_cal[15] == 1'b0)
    else $error("cal msb set");
  chk_cal_follows: assert property (i_reg_wr && i_reg_addr == 8'h05 |=>
    o_cal == {1'b0, $past(i_reg_wdata[14:0])}) else $error("cal not updated");
  chk_limit_read: assert property (i_reg_rd && i_reg_addr == 8'h07 |=>
    o_reg_rdata == $past(lim_q)) else $error("limit readback wrong");
  chk_mask_gap_zero: assert property (i_reg_rd && i_reg_addr == 8'h06 |=>
    o_reg_rdata[9:5] == 5'h00) else $error("mask gap bits set");
  chk_bad_addr_zero: assert property (i_reg_rd && (i_reg_addr < 8'h05 ||
    i_reg_addr > 8'h07) |=> o_reg_rdata == 16'h0000) else $error("unmapped read nonzero");
  chk_current_pulse: assert property (i_conv_done && !i_conv_kind |-> ##2
    o_current_valid) else $error("no current result");
  chk_sense_over: assert property (i_conv_done && !i_conv_kind && msk_q[15] &&
    $signed(i_sense_code) > $signed(lim_q) |=> o_alert_oe != msk_q[1])
    else $error("sense over not alerted");
  chk_bus_over: assert property (i_conv_done && i_conv_kind && msk_q[15:13] == 3'h1
    && i_bus_code > lim_q |=> o_alert_oe != msk_q[1]) else $error("bus over not alerted");
  chk_pin_low_only: assert property (o_alert_out == 1'b0)
    else $error("alert pin driven high");
endmodule // alc_alert_limit_asserts
bind alc_alert_limit alc_alert_limit_asserts alc_alert_limit_asserts_i (.i_clk_sys,
  .i_nrst, .i_reg_wr, .i_reg_rd, .i_conv_done, .i_conv_kind, .i_reg_addr, .i_reg_wdata,
  .o_reg_rdata, .i_sense_code, .i_bus_code, .o_current_valid, .o_alert_out, .o_alert_oe,
  .o_cal);

// ---- sim/alc_host_model.sv ----
`timescale 1ns/100ps
// host side of the register port; drives at the falling edge
module alc_host_model (
  // clock
  input wire i_clk_sys,
  // answers from the block
  input wire [15:0] i_reg_rdata,
  input wire i_reg_rvalid,
  // requests to the block
  output reg [7:0] o_reg_addr,
  output reg o_reg_wr,
  output reg [15:0] o_reg_wdata,
  output reg o_reg_rd
);
  initial begin
    o_reg_addr = 8'h00;
    o_reg_wr = 1'b0;
    o_reg_wdata = 16'h0000;
    o_reg_rd = 1'b0;
  end
  task wr(input [7:0] a, input [15:0] d);
    begin
      @(negedge i_clk_sys);
      o_reg_addr = a;
      o_reg_wdata = d;
      o_reg_wr = 1'b1;
      @(negedge i_clk_sys);
      o_reg_wr = 1'b0;
      // data no longer valid once the strobe drops
      o_reg_wdata = ~d;
    end
  endtask
  task rd(input [7:0] a, output [15:0] d);
    begin
      @(negedge i_clk_sys);
      o_reg_addr = a;
      o_reg_rd = 1'b1;
      @(negedge i_clk_sys);
      o_reg_rd = 1'b0;
      d = i_reg_rvalid ? i_reg_rdata : 16'hXXXX;
    end
  endtask
endmodule // alc_host_model

// ---- sim/tb_alert_limit_compare_logic.sv ----
`timescale 1ns/100ps
module tb_alert_limit_compare_logic;
  reg clk = 1'b0;
  reg nrst = 1'b0;
  reg cv = 1'b0, kd = 1'b0, cy = 1'b0, cw = 1'b0, pd = 1'b0, pv = 1'b0;
  reg [15:0] sc = 16'h0000, bc = 16'h0000, pw = 16'h0000, r;
  wire [7:0] ad;
  wire wr, rd, rv, cur_v, a_out, a_oe;
  wire [15:0] wd, rdat, cur, cal;
  integer mismatches = 0, n_tests = 0, i;
  initial begin
    forever #2 clk = ~clk;
  end
  alc_host_model alc_host_model_i (.i_clk_sys(clk), .i_reg_rdata(rdat), .i_reg_rvalid(rv),
    .o_reg_addr(ad), .o_reg_wr(wr), .o_reg_wdata(wd), .o_reg_rd(rd));
  alc_alert_limit alc_alert_limit_i (.i_clk_sys(clk), .i_nrst(nrst), .i_reg_addr(ad),
    .i_reg_wr(wr), .i_reg_wdata(wd), .i_reg_rd(rd), .o_reg_rdata(rdat), .o_reg_rvalid(rv),
    .i_conv_done(cv), .i_conv_kind(kd), .i_sense_code(sc), .i_bus_code(bc),
    .i_cycle_done(cy), .i_cfg_wr(cw), .i_cfg_pd(pd), .i_power_valid(pv), .i_power(pw),
    .i_power_ovf(1'b0), .o_current(cur), .o_current_valid(cur_v), .o_cal(cal),
    .i_alert_pin(1'b1), .o_alert_out(a_out), .o_alert_oe(a_oe));
  task chk(input [63:0] nm, input [15:0] e, input [15:0] s);
    begin
      n_tests = n_tests + 1;
      if (s !== e) begin
        mismatches = mismatches + 1;
        $display("BAD %0s expected %h seen %h", nm, e, s);
      end
    end
  endtask
  task wr_reg(input [7:0] a, input [15:0] d);
    alc_host_model_i.wr(a, d);
  endtask
  task rc(input [7:0] a, input [15:0] e);
    begin
      alc_host_model_i.rd(a, r);
      chk("rdata", e, r);
    end
  endtask
  // one conversion result, sampled two edges later
  task cnv(input k, input [15:0] d);
    begin
      @(negedge clk);
      {cv, kd, sc, bc} = {1'b1, k, d, d};
      @(negedge clk);
      cv = 1'b0;
      @(negedge clk);
    end
  endtask
  task pwr(input [15:0] p);
    begin
      cnv(1'b1, 16'h0200);
      @(negedge clk);
      {pv, pw} = {1'b1, p};
      @(negedge clk);
      pv = 1'b0;
      @(negedge clk);
    end
  endtask
  // end of cycle, then a configuration write once the done flag has been set
  task cyc(input c, input p);
    begin
      @(negedge clk);
      cy = 1'b1;
      @(negedge clk);
      cy = 1'b0;
      @(negedge clk);
      {cw, pd} = {c, p};
      @(negedge clk);
      cw = 1'b0;
      @(negedge clk);
    end
  endtask
  task t_regs;
    begin
      for (i = 5; i < 8; i = i + 1) rc(i, 16'h0000);
      chk("alert", 1'b0, a_oe);
      wr_reg(8'h08, 16'hFFFF);
      rc(8'h08, 16'h0000);
      wr_reg(8'h06, 16'hFFFF);
      rc(8'h06, 16'hFC03);
      wr_reg(8'h06, 16'h0000);
      wr_reg(8'h05, 16'hFFFF);
      rc(8'h05, 16'h7FFF);
      chk("cal", 16'h7FFF, cal);
      wr_reg(8'h05, 16'h0003);
      cnv(1'b0, 16'hFFFE);
      chk("current", 16'hFFFA, cur);
      wr_reg(8'h05, 16'h7FFF);
      cnv(1'b0, 16'h7FFF);
      chk("current", 16'h7FFF, cur);
      rc(8'h06, 16'h0004);
      $display("t_regs done");
    end
  endtask
  task t_cmp;
    begin
      wr_reg(8'h05, 16'h0001);
      wr_reg(8'h07, 16'h0100);
      rc(8'h07, 16'h0100);
      wr_reg(8'h06, 16'hA000);
      cnv(1'b1, 16'h0200);
      chk("alert", 1'b0, a_oe);
      cnv(1'b0, 16'h0200);
      chk("alert", 1'b1, a_oe);
      cnv(1'b0, 16'h0050);
      chk("alert", 1'b0, a_oe);
      rc(8'h06, 16'hA000);
      wr_reg(8'h06, 16'h4000);
      cnv(1'b0, 16'hFF00);
      chk("alert", 1'b1, a_oe);
      wr_reg(8'h06, 16'h1000);
      cnv(1'b1, 16'h0050);
      chk("alert", 1'b1, a_oe);
      cnv(1'b1, 16'h8000);
      chk("alert", 1'b0, a_oe);
      wr_reg(8'h06, 16'h0800);
      pwr(16'h0200);
      chk("alert", 1'b1, a_oe);
      pwr(16'h0050);
      chk("alert", 1'b0, a_oe);
      $display("t_cmp done");
    end
  endtask
  task t_latch;
    begin
      wr_reg(8'h06, 16'h2001);
      cnv(1'b1, 16'h0200);
      chk("alert", 1'b1, a_oe);
      cnv(1'b1, 16'h0050);
      chk("alert", 1'b1, a_oe);
      rc(8'h06, 16'h2011);
      @(negedge clk);
      chk("alert", 1'b0, a_oe);
      rc(8'h06, 16'h2001);
      $display("t_latch done");
    end
  endtask
  task t_ready;
    begin
      wr_reg(8'h06, 16'h0400);
      cyc(1'b0, 1'b0);
      chk("alert", 1'b1, a_oe);
      rc(8'h06, 16'h0408);
      rc(8'h06, 16'h0400);
      cyc(1'b1, 1'b1);
      rc(8'h06, 16'h0408);
      cyc(1'b1, 1'b0);
      rc(8'h06, 16'h0400);
      wr_reg(8'h06, 16'h2400);
      cyc(1'b0, 1'b0);
      cnv(1'b1, 16'h0050);
      chk("alert", 1'b1, a_oe);
      $display("t_ready done");
    end
  endtask
  task t_pol;
    begin
      wr_reg(8'h06, 16'h0002);
      rc(8'h06, 16'h000A);
      chk("alert", 1'b1, a_oe);
      wr_reg(8'h06, 16'h2002);
      cnv(1'b1, 16'h0200);
      chk("alert", 1'b0, a_oe);
      $display("t_pol done");
    end
  endtask
  task finish_test;
    begin
      $display("comparisons %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) begin
        $display("Finished cleanly");
      end else begin
        $display("Finished with errors");
      end
      $finish;
    end
  endtask
  initial begin
    repeat (20) @(negedge clk);
    nrst = 1'b1;
    t_regs;
    t_cmp;
    t_latch;
    t_ready;
    t_pol;
    finish_test;
  end
endmodule // tb_alert_limit_compare_logic
